// >>> rps_cal_if.sv
// Calendar load and time-of-day carrier
`timescale 1ns/1ps
interface rps_cal_if;
  import rps_pkg::*;
  logic      load;
  rps_time_t set;
  rps_time_t now;
  logic      tick;
  modport cal (input load, input set, output now, output tick);
  modport user (output load, output set, input now, input tick);
endinterface

// >>> rps_calendar.sv
// Minute, hour and weekday counter
`timescale 1ns/1ps
`include "rps_cfg.svh"
module rps_calendar
  import rps_pkg::*;
#(
  parameter int CYC_PER_SEC = `RPS_CYC_PER_SEC,
  parameter int SEC_PER_MIN = `RPS_SEC_PER_MIN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  rps_cal_if.cal   bus
);
  localparam int CW = $clog2(CYC_PER_SEC);
  localparam int SW = $clog2(SEC_PER_MIN);
  if (CYC_PER_SEC < 2 || SEC_PER_MIN < 2) begin : g_chk
    $error("rps_calendar: prescaler counts must be at least 2");
  end
  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [SW-1:0] sec;
    rps_time_t     now;
    logic          tick;
  } rps_cal_st_t;
  rps_cal_st_t s;
  rps_cal_st_t next_s;
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (bus.load) begin
      next_s.now = bus.set;
      next_s.cyc = '0;
      next_s.sec = '0;
    end else if (s.cyc != CW'(CYC_PER_SEC - 1)) begin
      next_s.cyc = s.cyc + CW'(1);
    end else begin
      next_s.cyc = '0;
      if (s.sec != SW'(SEC_PER_MIN - 1)) begin
        next_s.sec = s.sec + SW'(1);
      end else begin
        next_s.sec = '0;
        next_s.tick = 1'b1;
        if (s.now.tod.mn != `RPS_LAST_MIN) begin
          next_s.now.tod.mn = s.now.tod.mn + 6'h01;
        end else begin
          next_s.now.tod.mn = 6'h00;
          if (s.now.tod.hr != `RPS_LAST_HR) begin
            next_s.now.tod.hr = s.now.tod.hr + 5'h01;
          end else begin
            next_s.now.tod.hr = 5'h00;
            // Weekday runs Monday to Sunday
            next_s.now.day = (s.now.day == `RPS_DAY_SUN) ? `RPS_DAY_MON
                                                         : s.now.day + 3'h1;
          end
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cyc: '0, sec: '0, now: '{day: `RPS_DAY_MON, tod: '0}, tick: 1'b0};
    end else if (ce) begin
      s <= next_s;
    end
  end
  assign bus.now  = s.now;
  assign bus.tick = s.tick;
  a_day_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    ce && next_s.tick && !bus.load && s.now == rps_time_t'{day: `RPS_DAY_SUN,
      tod: '{hr: `RPS_LAST_HR, mn: `RPS_LAST_MIN}} |=> s.now.day == `RPS_DAY_MON
      && s.now.tod == '0)
    else $error("weekday did not wrap to Monday");
endmodule

// >>> rps_cfg.svh
// Constants of the real-time-clock period scheduler
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH
`define RPS_CLK_HZ      250000000
`define RPS_SEC_TIME    1
`define RPS_CYC_PER_SEC (`RPS_CLK_HZ * `RPS_SEC_TIME)
`define RPS_SEC_PER_MIN 60
`define RPS_LAST_MIN    6'h3B
`define RPS_LAST_HR     5'h17
`define RPS_DAY_MON     3'h1
`define RPS_DAY_SUN     3'h7
`define RPS_A_CTRL      12'h000
`define RPS_A_CLOCK     12'h004
`define RPS_A_PER0      12'h008
`define RPS_A_STEP      12'h004
`define RPS_A_TSRC      12'h018
`define RPS_A_OFS       12'h01C
`define RPS_A_RELAY     12'h020
`define RPS_A_STAT      12'h024
`define RPS_TSRC_STRIDE 8
`define RPS_RSEL_STRIDE 4
`define RPS_FN_OFF      2'h0
`define RPS_FN_ON       2'h1
`define RPS_FN_DI       2'h2
`define RPS_SPD_OFF     3'h0
`define RPS_SPD_FIRST   3'h1
`define RPS_SPD_LAST    3'h4
`define RPS_SPD_PAIR    3'h5
`define RPS_RUN_SCHED   3'h4
`define RPS_LOCK_FWD    2'h1
`define RPS_LOCK_REV    2'h2
`define RPS_DI_FW       6
`define RPS_DI_OFFSET   6'h38
`define RPS_DI_TIMER    6'h3E
`define RPS_DI_FIRE     6'h3F
`define RPS_CTRL_RST    16'h0000
`endif

// >>> rps_drive_model.sv
// Drive-side model: stop key of the panel
`timescale 1ns/1ps
module rps_drive_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stop_req,
  input  wire logic run_cmd,
  output logic      manual_stop
);
  // Key only pressed while running, one cycle late like a panel button
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_stop <= 1'b0;
    end else begin
      manual_stop <= stop_req & run_cmd;
    end
  end
endmodule

// >>> rps_period_match.sv
// One time period: weekday range and inclusive time-of-day window
`timescale 1ns/1ps
`include "rps_cfg.svh"
module rps_period_match
  import rps_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  ce,
  input  rps_time_t  now,
  input  rps_period_t cfg,
  output logic       active
);
  typedef struct packed {
    logic act;
  } rps_pm_st_t;
  rps_pm_st_t s;
  rps_pm_st_t next_s;
  logic day_in;
  logic tod_in;
  always_comb begin
    next_s = s;
    // Ranges that run past Sunday or past midnight wrap around
    if (cfg.sday <= cfg.eday) begin
      day_in = now.day >= cfg.sday && now.day <= cfg.eday;
    end else begin
      day_in = now.day >= cfg.sday || now.day <= cfg.eday;
    end
    if (cfg.start < cfg.stop) begin
      tod_in = now.tod >= cfg.start && now.tod <= cfg.stop;
    end else begin
      tod_in = now.tod >= cfg.start || now.tod <= cfg.stop;
    end
    next_s.act = (cfg.start != cfg.stop) && day_in && tod_in;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
  assign active = s.act;
  a_equal_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.start == cfg.stop |=> !active)
    else $error("period with equal start and stop became active");
  a_stop_incl: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.start < cfg.stop && now.tod == cfg.stop && day_in |=> active)
    else $error("stop minute not inclusive");
endmodule

// >>> rps_pkg.sv
// Types shared by the scheduler modules
package rps_pkg;
  typedef struct packed {
    logic [4:0] hr;
    logic [5:0] mn;
  } rps_clk_t;
  typedef struct packed {
    logic [2:0] day;
    rps_clk_t   tod;
  } rps_time_t;
  typedef struct packed {
    logic [2:0] eday;
    logic [2:0] sday;
    rps_clk_t   stop;
    rps_clk_t   start;
  } rps_period_t;
  typedef struct packed {
    logic [1:0] lock;
    logic [3:0] dir;
    logic [2:0] rsrc;
    logic [2:0] spd;
    logic [1:0] osel;
    logic [1:0] tfunc;
  } rps_ctrl_t;
  typedef enum logic {
    RPS_OFS_IDLE = 1'b0,
    RPS_OFS_RUN  = 1'b1
  } rps_ofs_st_t;
endpackage

// >>> rps_scheduler.sv
// Real-time-clock period scheduler with APB registers
`timescale 1ns/1ps
`include "rps_cfg.svh"
module rps_scheduler
  import rps_pkg::*;
#(
  parameter int N_DI        = 6,
  parameter int N_RELAY     = 2,
  parameter int CYC_PER_SEC = `RPS_CYC_PER_SEC,
  parameter int SEC_PER_MIN = `RPS_SEC_PER_MIN
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  input  wire logic [11:0]                  paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [N_DI-1:0]              di_level,
  input  wire logic [N_DI*`RPS_DI_FW-1:0]   di_func,
  input  wire logic                         power_loss_ride_through,
  input  wire logic                         manual_stop,
  output logic                              run_cmd,
  output logic                              reverse_cmd,
  output logic [1:0]                        speed_stage,
  output logic                              speed_ctrl,
  output logic [N_RELAY-1:0]                relay_out
);
  if (N_DI < 1 || N_RELAY < 1 || N_RELAY > 8) begin : g_chk
    $error("rps_scheduler: N_DI must be >= 1 and N_RELAY 1 to 8");
  end
  typedef struct packed {
    rps_ctrl_t                 ctrl;
    rps_period_t [3:0]         per;
    logic [3:0][4:0]           tsrc;
    rps_clk_t                  ofs_time;
    logic [N_RELAY-1:0][2:0]   rsel;
    rps_ofs_st_t               ofs_st;
    rps_clk_t                  ofs_cnt;
    logic                      osel_prev;
    logic                      di_ofs_prev;
    logic                      gov_per_prev;
    logic                      hold;
    logic                      ok;
    logic                      err;
    logic [31:0]               rdata;
    logic                      run;
    logic                      rev;
    logic [1:0]                stage;
    logic                      spd_ctrl;
    logic [N_RELAY-1:0]        relay;
  } rps_main_st_t;
  rps_main_st_t s;
  rps_main_st_t next_s;

  rps_cal_if cal_bus ();
  logic [N_DI-1:0]    ofs_hit;
  logic [N_DI-1:0]    tim_hit;
  logic [N_DI-1:0]    fire_hit;
  logic [3:0]         pact;
  logic [3:0]         pact_g;
  logic [3:0]         tim;
  logic [3:0]         tper;
  logic [N_RELAY-1:0] relay_c;
  logic               suppress;
  logic               en;
  logic               di_ofs;
  logic               osel_on;
  logic               ofs_start;
  logic               off_act;
  logic               gov;
  logic               gov_per;
  logic [1:0]         idx;
  logic               req_rev;
  logic               lock_ok;
  logic               wr;
  logic               hit;
  logic [31:0]        rd;

  rps_calendar #(
    .CYC_PER_SEC (CYC_PER_SEC),
    .SEC_PER_MIN (SEC_PER_MIN)
  ) u_cal (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .bus     (cal_bus.cal)
  );

  for (genvar i = 0; i < N_DI; i++) begin : g_di
    logic [`RPS_DI_FW-1:0] fn;
    assign fn          = di_func[i*`RPS_DI_FW +: `RPS_DI_FW];
    assign ofs_hit[i]  = di_level[i] && fn == `RPS_DI_OFFSET;
    assign tim_hit[i]  = di_level[i] && fn == `RPS_DI_TIMER;
    assign fire_hit[i] = fn == `RPS_DI_FIRE;
  end

  for (genvar p = 0; p < 4; p++) begin : g_per
    rps_period_match u_pm (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .now     (cal_bus.now),
      .cfg     (s.per[p]),
      .active  (pact[p])
    );
  end

  assign suppress = |fire_hit || power_loss_ride_through;
  assign en = !suppress && (s.ctrl.tfunc == `RPS_FN_ON ||
              (s.ctrl.tfunc == `RPS_FN_DI && |tim_hit));
  assign pact_g  = en ? pact : 4'h0;
  assign di_ofs  = |ofs_hit;
  assign osel_on = en && s.ctrl.osel == `RPS_FN_ON;
  // Offset starts on an edge so a held input does not retrigger
  assign ofs_start = (osel_on && !s.osel_prev) ||
                     (en && s.ctrl.osel == `RPS_FN_DI && di_ofs && !s.di_ofs_prev);
  assign off_act = en && s.ofs_st == RPS_OFS_RUN;

  for (genvar t = 0; t < 4; t++) begin : g_tim
    assign tper[t] = |(s.tsrc[t][3:0] & pact_g);
    assign tim[t]  = tper[t] || (s.tsrc[t][4] && off_act);
  end

  for (genvar r = 0; r < N_RELAY; r++) begin : g_rly
    // Codes 1 to 4 pick one timer, anything else leaves the relay off
    assign relay_c[r] = (s.rsel[r] >= 3'h1 && s.rsel[r] <= 3'h4) ?
                        tim[2'(s.rsel[r] - 3'h1)] : 1'b0;
  end

  assign lock_ok = !(req_rev && s.ctrl.lock == `RPS_LOCK_FWD) &&
                   !(!req_rev && s.ctrl.lock == `RPS_LOCK_REV);
  assign wr  = psel && penable && pwrite && s.ok;
  assign cal_bus.load = ce && wr && paddr == `RPS_A_CLOCK;
  assign cal_bus.set  = rps_time_t'(pwdata[13:0]);

  always_comb begin
    next_s  = s;
    gov     = 1'b0;
    gov_per = 1'b0;
    idx     = 2'h0;
    req_rev = 1'b0;
    hit     = 1'b0;
    rd      = 32'h0000_0000;
    if (s.ctrl.spd >= `RPS_SPD_FIRST && s.ctrl.spd <= `RPS_SPD_LAST) begin
      gov     = tim[2'(s.ctrl.spd - 3'h1)];
      gov_per = tper[2'(s.ctrl.spd - 3'h1)];
      req_rev = s.ctrl.dir[2'(s.ctrl.spd - 3'h1)];
    end else if (s.ctrl.spd == `RPS_SPD_PAIR) begin
      gov     = en;
      gov_per = tper[0] || tper[1];
      idx     = {tim[1], tim[0]};
      req_rev = s.ctrl.dir[idx];
    end
    // Register read mux and decode
    unique case (paddr)
      `RPS_A_CTRL: begin
        hit = 1'b1;
        rd  = {16'h0000, s.ctrl};
      end
      `RPS_A_CLOCK: begin
        hit = 1'b1;
        rd  = {18'h00000, cal_bus.now};
      end
      `RPS_A_TSRC: begin
        hit = 1'b1;
        for (int t = 0; t < 4; t++) begin
          rd[t*`RPS_TSRC_STRIDE +: 5] = s.tsrc[t];
        end
      end
      `RPS_A_OFS: begin
        hit = 1'b1;
        rd  = {21'h000000, s.ofs_time};
      end
      `RPS_A_RELAY: begin
        hit = 1'b1;
        for (int r = 0; r < N_RELAY; r++) begin
          rd[r*`RPS_RSEL_STRIDE +: 3] = s.rsel[r];
        end
      end
      `RPS_A_STAT: begin
        hit = 1'b1;
        rd  = {17'h00000, s.stage, s.rev, s.run, en, s.hold, off_act, tim, pact_g};
      end
      default: begin
        for (int p = 0; p < 4; p++) begin
          if (paddr == `RPS_A_PER0 + 12'(p) * `RPS_A_STEP) begin
            hit = 1'b1;
            rd  = {4'h0, s.per[p]};
          end
        end
      end
    endcase
    // Read data and error are captured before pready, so they come from flops
    if (psel && !s.ok) begin
      next_s.rdata = rd;
      next_s.err   = !hit;
    end
    next_s.ok = psel && !(penable && s.ok);
    if (wr) begin
      if (paddr == `RPS_A_CTRL) next_s.ctrl = rps_ctrl_t'(pwdata[15:0]);
      if (paddr == `RPS_A_OFS) next_s.ofs_time = rps_clk_t'(pwdata[10:0]);
      if (paddr == `RPS_A_TSRC) begin
        for (int t = 0; t < 4; t++) begin
          next_s.tsrc[t] = pwdata[t*`RPS_TSRC_STRIDE +: 5];
        end
      end
      if (paddr == `RPS_A_RELAY) begin
        for (int r = 0; r < N_RELAY; r++) begin
          next_s.rsel[r] = pwdata[r*`RPS_RSEL_STRIDE +: 3];
        end
      end
      for (int p = 0; p < 4; p++) begin
        if (paddr == `RPS_A_PER0 + 12'(p) * `RPS_A_STEP) begin
          next_s.per[p] = rps_period_t'(pwdata[27:0]);
        end
      end
    end
    // Offset duration counts down in whole minutes
    next_s.osel_prev   = osel_on;
    next_s.di_ofs_prev = di_ofs;
    unique case (s.ofs_st)
      RPS_OFS_IDLE: begin
        if (ofs_start && s.ofs_time != '0) begin
          next_s.ofs_st  = RPS_OFS_RUN;
          next_s.ofs_cnt = s.ofs_time;
        end
      end
      RPS_OFS_RUN: begin
        if (!en || s.ctrl.osel == `RPS_FN_OFF) begin
          next_s.ofs_st = RPS_OFS_IDLE;
        end else if (cal_bus.tick) begin
          if (s.ofs_cnt == '0) begin
            next_s.ofs_st = RPS_OFS_IDLE;
          end else if (s.ofs_cnt.mn == 6'h00) begin
            next_s.ofs_cnt = '{hr: s.ofs_cnt.hr - 5'h01, mn: `RPS_LAST_MIN};
          end else begin
            next_s.ofs_cnt.mn = s.ofs_cnt.mn - 6'h01;
          end
        end
      end
    endcase
    // Stop wins over a period start in the same cycle
    next_s.gov_per_prev = gov_per;
    if (manual_stop && s.run) begin
      next_s.hold = 1'b1;
    end else if ((gov_per && !s.gov_per_prev) || ofs_start) begin
      next_s.hold = 1'b0;
    end
    next_s.spd_ctrl = en && s.ctrl.spd >= `RPS_SPD_FIRST &&
                      s.ctrl.spd <= `RPS_SPD_PAIR;
    next_s.run = next_s.spd_ctrl && s.ctrl.rsrc == `RPS_RUN_SCHED && gov &&
                 !s.hold && lock_ok;
    next_s.rev   = req_rev;
    next_s.stage = idx;
    next_s.relay = en ? relay_c : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.ctrl  <= rps_ctrl_t'(`RPS_CTRL_RST);
      s.ofs_st <= RPS_OFS_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign pready      = ce && s.ok;
  assign pslverr     = psel && penable && s.ok && s.err;
  assign prdata      = s.rdata;
  assign run_cmd     = s.run;
  assign reverse_cmd = s.rev;
  assign speed_stage = s.stage;
  assign speed_ctrl  = s.spd_ctrl;
  assign relay_out   = s.relay;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_runsrc_gate: assert property (
    ce && s.ctrl.rsrc != `RPS_RUN_SCHED |=> !run_cmd)
    else $error("run without scheduler run source");
  a_speed_off: assert property (
    ce && s.ctrl.spd == `RPS_SPD_OFF |=> !run_cmd && !speed_ctrl)
    else $error("speed selection 0 still controls drive");
  a_suppress_all: assert property (
    ce && suppress |=> !run_cmd && relay_out == '0 && !speed_ctrl)
    else $error("scheduler acted while suppressed");
  a_pair_stage: assert property (
    ce && s.ctrl.spd == `RPS_SPD_PAIR |=> speed_stage == $past({tim[1], tim[0]}))
    else $error("pair mode stage not from timers one and two");
  a_single_stage: assert property (
    ce && s.ctrl.spd == `RPS_SPD_FIRST |=> speed_stage == 2'h0 &&
    run_cmd == $past(en && s.ctrl.rsrc == `RPS_RUN_SCHED && tim[0] && !s.hold
                     && lock_ok))
    else $error("single timer mode wrong");
  a_dir_lock: assert property (
    ce && s.ctrl.lock == `RPS_LOCK_FWD |=> !(run_cmd && reverse_cmd))
    else $error("locked reverse direction commanded");
  a_hold_stop: assert property (
    ce && manual_stop && run_cmd |=> s.hold ##1 !run_cmd)
    else $error("manual stop did not hold drive");
  a_offset_now: assert property (
    ce && ofs_start && s.ofs_time != '0 && s.ofs_st == RPS_OFS_IDLE |=> off_act)
    else $error("offset input did not start at once");
  a_src_zero: assert property (
    ce && s.tsrc[0] == 5'h00 && s.ctrl.spd == `RPS_SPD_FIRST |=> !run_cmd)
    else $error("timer with source 0 ran drive");
  a_relay_none: assert property (
    ce && s.rsel[0] == 3'h0 |=> !relay_out[0])
    else $error("unassigned relay switched");

  c_run_start: cover property (ce && !run_cmd ##1 run_cmd);
  c_pair_top:  cover property (s.ctrl.spd == `RPS_SPD_PAIR && speed_stage == 2'h3);
  c_hold_set:  cover property (!s.hold ##1 s.hold);
  c_offset:    cover property (off_act && run_cmd);
endmodule

// >>> test_rps_scheduler.sv
// Testbench of the period scheduler over its register bus
`timescale 1ns/1ps
`include "rps_cfg.svh"
module test_rps_scheduler;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  di_level;
  logic [35:0] di_func;
  logic        plrt;
  logic        manual_stop;
  logic        stop_req;
  logic        run_cmd;
  logic        reverse_cmd;
  logic [1:0]  speed_stage;
  logic        speed_ctrl;
  logic [1:0]  relay_out;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          i;
  localparam logic [10:0] T_END = {`RPS_LAST_HR, `RPS_LAST_MIN};
  localparam logic [31:0] P_ALL = {4'h0, 3'h7, 3'h1, T_END, 11'h000};
  localparam logic [11:0] A_CT = `RPS_A_CTRL;
  localparam logic [11:0] A_TS = `RPS_A_TSRC;
  localparam logic [11:0] A_P1 = `RPS_A_PER0;
  localparam logic [11:0] A_P2 = `RPS_A_PER0 + `RPS_A_STEP;

  rps_scheduler #(.CYC_PER_SEC(4), .SEC_PER_MIN(3)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .di_level(di_level), .di_func(di_func),
    .power_loss_ride_through(plrt), .manual_stop(manual_stop), .run_cmd(run_cmd),
    .reverse_cmd(reverse_cmd), .speed_stage(speed_stage), .speed_ctrl(speed_ctrl),
    .relay_out(relay_out));
  rps_drive_model model_u (.pclk(pclk), .presetn(presetn), .stop_req(stop_req),
    .run_cmd(run_cmd), .manual_stop(manual_stop));

  always #2 pclk = ~pclk;

  function automatic logic [31:0] ctl(input logic [1:0] tf, input logic [1:0] os,
      input logic [2:0] sp, input logic [2:0] rs, input logic [3:0] dr,
      input logic [1:0] lk);
    return {16'h0000, lk, dr, rs, sp, os, tf};
  endfunction
  // Monday-only window
  function automatic logic [31:0] per(input logic [10:0] s, input logic [10:0] e);
    return {4'h0, 3'h1, 3'h1, e, s};
  endfunction

  task automatic give_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer, then an idle cycle so no signal is set twice at one edge
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic st;
    repeat (4) @(posedge pclk);
  endtask
  task automatic ck(input logic e);
    st;
    chk("run_cmd", e, run_cmd);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      give_verdict;
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    di_level = 6'h00;
    di_func = 36'h0;
    plrt = 1'b0;
    stop_req = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("relay", 0, relay_out);
    xf(0, A_CT, 0);
    chk("ctrl", `RPS_CTRL_RST, rdat);
    xf(0, 12'h0FC, 0);
    chk("pslverr", 1, rerr);
    chk("rd_bad", 0, rdat);
    xf(1, A_P1, P_ALL);
    xf(1, A_P2, {4'h0, 3'h7, 3'h1, 22'h0});
    xf(1, A_P1 + 12'h008, P_ALL);
    xf(1, A_CT, ctl(2'h1, 2'h0, 3'h1, 3'h4, 4'h0, 2'h0));
    for (i = 0; i < 32; i++) begin
      xf(1, A_TS, i);
      st;
      xf(0, `RPS_A_STAT, 0);
      chk("timer1", |(i[3:0] & 4'h5), rdat[4]);
      chk("run_cmd", |(i[3:0] & 4'h5), run_cmd);
    end
    chk("periods", 4'h5, rdat[3:0]);
    xf(1, `RPS_A_OFS, 32'h2);
    xf(1, A_TS, 32'h10);
    xf(1, A_CT, ctl(2'h1, 2'h1, 3'h1, 3'h4, 4'h0, 2'h0));
    ck(1'b1);
    repeat (40) @(posedge pclk);
    chk("run_cmd", 0, run_cmd);
    di_func <= {30'h0, `RPS_DI_OFFSET};
    xf(1, A_CT, ctl(2'h1, 2'h2, 3'h1, 3'h4, 4'h0, 2'h0));
    ck(1'b0);
    di_level <= 6'h01;
    ck(1'b1);
    repeat (40) @(posedge pclk);
    chk("run_cmd", 0, run_cmd);
    di_level <= 6'h00;
    for (i = 1; i < 5; i++) begin
      xf(1, A_CT, ctl(2'h1, 2'h0, i[2:0], 3'h4, 4'hA, 2'h0));
      xf(1, A_TS, 32'h1 << (8 * (i % 4)));
      ck(1'b0);
      xf(1, A_TS, 32'h1 << (8 * (i - 1)));
      ck(1'b1);
      chk("reverse", !i[0], reverse_cmd);
      chk("stage", 0, speed_stage);
      chk("spd_ctrl", 1, speed_ctrl);
    end
    xf(1, A_CT, ctl(2'h1, 2'h0, 3'h0, 3'h4, 4'h0, 2'h0));
    st;
    chk("spd_ctrl", 0, speed_ctrl);
    xf(1, A_CT, ctl(2'h1, 2'h0, 3'h5, 3'h4, 4'h6, 2'h0));
    for (i = 0; i < 4; i++) begin
      xf(1, A_TS, {23'h0, i[1], 7'h0, i[0]});
      ck(1'b1);
      chk("stage", i[1:0], speed_stage);
      chk("reverse", i[0] ^ i[1], reverse_cmd);
    end
    xf(1, A_TS, 32'h1);
    xf(1, A_CT, ctl(2'h1, 2'h0, 3'h1, 3'h4, 4'h1, 2'h1));
    ck(1'b0);
    xf(1, A_CT, ctl(2'h1, 2'h0, 3'h1, 3'h4, 4'h1, 2'h2));
    ck(1'b1);
    chk("reverse", 1, reverse_cmd);
    for (i = 0; i < 4; i++) begin
      xf(1, A_CT, ctl(2'h1, 2'h0, 3'h1, i[2:0], 4'h0, 2'h0));
      ck(1'b0);
    end
    xf(1, A_CT, ctl(2'h1, 2'h0, 3'h1, 3'h4, 4'h0, 2'h0));
    plrt <= 1'b1;
    ck(1'b0);
    plrt <= 1'b0;
    ck(1'b1);
    di_func <= {24'h0, `RPS_DI_FIRE, 6'h00};
    ck(1'b0);
    di_func <= {18'h0, `RPS_DI_TIMER, 12'h000};
    xf(1, A_CT, ctl(2'h0, 2'h0, 3'h1, 3'h4, 4'h0, 2'h0));
    ck(1'b0);
    xf(1, A_CT, ctl(2'h2, 2'h0, 3'h1, 3'h4, 4'h0, 2'h0));
    ck(1'b0);
    di_level <= 6'h04;
    ck(1'b1);
    xf(1, `RPS_A_RELAY, 32'h31);
    st;
    chk("relay", 2'h1, relay_out);
    xf(1, `RPS_A_RELAY, 32'h11);
    st;
    chk("relay", 2'h3, relay_out);
    xf(1, A_P1 + 12'h008, 0);
    xf(1, A_P1, per({5'h0B, 6'h3B}, {5'h0C, 6'h00}));
    xf(1, `RPS_A_CLOCK, {18'h0, 3'h1, 5'h0C, 6'h00});
    repeat (8) @(posedge pclk);
    chk("run_cmd", 1, run_cmd);
    repeat (14) @(posedge pclk);
    chk("run_cmd", 0, run_cmd);
    xf(1, A_P1, per(11'h000, 11'h001));
    xf(1, `RPS_A_CLOCK, {18'h0, 3'h7, T_END});
    ck(1'b0);
    repeat (12) @(posedge pclk);
    chk("run_cmd", 1, run_cmd);
    xf(1, A_P1, per({5'h0B, 6'h00}, {5'h0C, 6'h01}));
    xf(1, A_P2, per({5'h0C, 6'h03}, {5'h0C, 6'h05}));
    xf(1, A_TS, 32'h3);
    xf(1, `RPS_A_CLOCK, {18'h0, 3'h1, 5'h0C, 6'h00});
    repeat (3) @(posedge pclk);
    chk("run_cmd", 1, run_cmd);
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    ck(1'b0);
    repeat (32) @(posedge pclk);
    chk("run_cmd", 1, run_cmd);
    give_verdict;
  end
endmodule
